// ===== logic/ct_timer_top.sv
/*
 * counter/timer with interrupt mask gating and out_port_bit3 drive.
 * assumes all inputs synchronous to clock; other status bits come from the serial channels.
 */
`timescale 1ns/1ps
module ct_timer_top (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       cs_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] data_in,
	output logic [7:0]      data_out,
	output logic            data_oe,
	input  wire logic       crystal_clock_in,
	input  wire logic       in_port_bit2,
	input  wire logic       chan_a_tx_1x_clock,
	input  wire logic       chan_b_tx_1x_clock,
	input  wire logic       chan_b_rx_1x_clock,
	input  wire logic       out_reg_bit3,
	input  wire logic [7:0] other_status,
	output logic            irq_out_n,
	output logic            out_port_bit3_out,
	output logic            out_port_bit3_oe
);

	// ----------------------------------------
	// bus access and source clock
	// ----------------------------------------
	logic       rd_pulse;
	logic       wr_pulse;
	logic [3:0] acc_addr;
	logic [7:0] acc_data;
	logic       tick;

	host_bus_port u_bus (
		.clock    (clock),
		.rst      (rst),
		.cs_n     (cs_n),
		.rd_n     (rd_n),
		.wr_n     (wr_n),
		.addr     (addr),
		.data_in  (data_in),
		.rd_pulse (rd_pulse),
		.wr_pulse (wr_pulse),
		.acc_addr (acc_addr),
		.acc_data (acc_data)
	);

	logic [2:0] mode_q;
	logic [2:0] mode_d;

	ct_clock_select u_src (
		.clock              (clock),
		.rst                (rst),
		.mode_sel           (mode_q),
		.in_port_bit2       (in_port_bit2),
		.chan_a_tx_1x_clock (chan_a_tx_1x_clock),
		.chan_b_tx_1x_clock (chan_b_tx_1x_clock),
		.crystal_clock_in   (crystal_clock_in),
		.tick               (tick)
	);

	// ----------------------------------------
	// write registers
	// ----------------------------------------
	logic [7:0]  irq_mask_reg_q;
	logic [7:0]  irq_mask_reg_d;
	logic [1:0]  outcfg_q;
	logic [1:0]  outcfg_d;
	logic [15:0] preset_q;
	logic [15:0] preset_d;
	logic        start_cmd;
	logic        stop_cmd;

	assign start_cmd = rd_pulse & (acc_addr == ct_pkg::ADDR_START);
	assign stop_cmd  = rd_pulse & (acc_addr == ct_pkg::ADDR_STOP);

	// no read path exists for the preset bytes
	always_comb begin
		irq_mask_reg_d = irq_mask_reg_q;
		mode_d         = mode_q;
		outcfg_d       = outcfg_q;
		preset_d       = preset_q;
		if (wr_pulse) begin
			case (acc_addr)
				ct_pkg::ADDR_MASK:      irq_mask_reg_d = acc_data;
				ct_pkg::ADDR_MODE:      mode_d = acc_data[ct_pkg::MODE_MSB:ct_pkg::MODE_LSB];
				ct_pkg::ADDR_OUTCFG:    outcfg_d = acc_data[ct_pkg::OUTCFG_MSB:ct_pkg::OUTCFG_LSB];
				ct_pkg::ADDR_PRESET_HI: preset_d = {acc_data, preset_q[7:0]};
				ct_pkg::ADDR_PRESET_LO: preset_d = {preset_q[15:8], acc_data};
				default:                preset_d = preset_q;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_mask_reg_q <= ct_pkg::MASK_RST;
			mode_q         <= ct_pkg::MODE_RST;
			outcfg_q       <= ct_pkg::OUTCFG_RST;
			preset_q       <= ct_pkg::PRESET_RST;
		end else begin
			irq_mask_reg_q <= irq_mask_reg_d;
			mode_q         <= mode_d;
			outcfg_q       <= outcfg_d;
			preset_q       <= preset_d;
		end
	end

	// ----------------------------------------
	// counter / timer core
	// ----------------------------------------
	ct_pkg::ct_state_t state_q;
	ct_pkg::ct_state_t state_d;
	logic [15:0]       count_q;
	logic [15:0]       count_d;
	logic              wave_q;
	logic              wave_d;
	logic              term_q;
	logic              term_d;
	logic              ready_q;
	logic              ready_d;
	logic              ready_set;
	logic              timer_mode;
	logic              at_one;

	assign timer_mode = mode_q[2];
	assign at_one     = (count_q <= ct_pkg::COUNT_ONE);

	always_comb begin
		state_d   = state_q;
		count_d   = count_q;
		wave_d    = wave_q;
		term_d    = term_q;
		ready_set = 1'b0;
		if (start_cmd) begin
			count_d = preset_q;
			wave_d  = 1'b1;
			term_d  = 1'b0;
			if (!timer_mode) begin
				state_d = ct_pkg::CT_RUN;
			end
		end else if (timer_mode) begin
			state_d = ct_pkg::CT_IDLE;
			term_d  = 1'b0;
			if (tick) begin
				if (at_one) begin
					count_d   = preset_q;
					wave_d    = ~wave_q;
					ready_set = ~wave_q;
				end else begin
					count_d = count_q - ct_pkg::COUNT_ONE;
				end
			end
		end else begin
			case (state_q)
				ct_pkg::CT_RUN: begin
					if (stop_cmd) begin
						state_d = ct_pkg::CT_IDLE;
						term_d  = 1'b0;
					end else if (tick) begin
						count_d = count_q - ct_pkg::COUNT_ONE;
						if (count_q == ct_pkg::COUNT_ONE) begin
							ready_set = 1'b1;
							term_d    = 1'b1;
						end
					end
				end
				ct_pkg::CT_IDLE: begin
					term_d = 1'b0;
				end
				default: begin
					state_d = ct_pkg::CT_IDLE;
				end
			endcase
		end
		// in timer mode a terminal event in the same cycle as a stop still lands; in counter mode the stop wins
		ready_d = (ready_q & ~stop_cmd) | ready_set;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= ct_pkg::CT_IDLE;
			count_q <= ct_pkg::COUNT_RST;
			wave_q  <= 1'b1;
			term_q  <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
			wave_q  <= wave_d;
			term_q  <= term_d;
			ready_q <= ready_d;
		end
	end

	// ----------------------------------------
	// status, interrupt and readback
	// ----------------------------------------
	logic [7:0] irq_status_reg;
	logic       irq_out_n_q;
	logic       irq_out_n_d;
	logic [7:0] data_out_q;
	logic [7:0] data_out_d;
	logic       data_oe_q;
	logic       data_oe_d;

	always_comb begin
		irq_status_reg            = other_status;
		irq_status_reg[ct_pkg::READY_BIT] = ready_q;
		irq_out_n_d = ~|(irq_status_reg & irq_mask_reg_q);
		data_oe_d   = ~cs_n & ~rd_n;
		data_out_d  = data_out_q;
		if (rd_pulse) begin
			case (acc_addr)
				ct_pkg::ADDR_STATUS:   data_out_d = irq_status_reg;
				ct_pkg::ADDR_COUNT_HI: data_out_d = count_q[15:8];
				ct_pkg::ADDR_COUNT_LO: data_out_d = count_q[7:0];
				default:               data_out_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_out_n_q <= 1'b1;
			data_out_q  <= 8'h00;
			data_oe_q   <= 1'b0;
		end else begin
			irq_out_n_q <= irq_out_n_d;
			data_out_q  <= data_out_d;
			data_oe_q   <= data_oe_d;
		end
	end

	// ----------------------------------------
	// out_port_bit3 drive
	// ----------------------------------------
	logic ct_level;
	logic op3_out_q;
	logic op3_out_d;
	logic op3_oe_q;
	logic op3_oe_d;

	assign ct_level = timer_mode ? wave_q : ~term_q;

	// mask plays no part here
	always_comb begin
		case (ct_pkg::op3_sel_t'(outcfg_q))
			ct_pkg::OP3_SEL_CT: begin
				op3_out_d = 1'b0;
				op3_oe_d  = ~ct_level;
			end
			ct_pkg::OP3_SEL_TXB: begin
				op3_out_d = chan_b_tx_1x_clock;
				op3_oe_d  = 1'b1;
			end
			ct_pkg::OP3_SEL_RXB: begin
				op3_out_d = chan_b_rx_1x_clock;
				op3_oe_d  = 1'b1;
			end
			default: begin
				op3_out_d = ~out_reg_bit3;
				op3_oe_d  = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			op3_out_q <= 1'b1;
			op3_oe_q  <= 1'b0;
		end else begin
			op3_out_q <= op3_out_d;
			op3_oe_q  <= op3_oe_d;
		end
	end

	assign irq_out_n         = irq_out_n_q;
	assign data_out          = data_out_q;
	assign data_oe           = data_oe_q;
	assign out_port_bit3_out = op3_out_q;
	assign out_port_bit3_oe  = op3_oe_q;

endmodule : ct_timer_top

// ===== logic/ct_pkg.sv
/*
 * constants, field layout and types shared by the counter/timer block.
 * assumes an eight-bit host bus with a four-bit register address.
 */
package ct_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int CNT_W  = 16;
	localparam int DIV_W  = 4;

	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [3:0] ADDR_MODE      = 4'h4; // write: mode and source
	localparam logic [3:0] ADDR_MASK      = 4'h5; // write: irq_mask_reg
	localparam logic [3:0] ADDR_STATUS    = 4'h5; // read: irq_status_reg
	localparam logic [3:0] ADDR_PRESET_HI = 4'h6; // write: preset_high_byte
	localparam logic [3:0] ADDR_COUNT_HI  = 4'h6; // read: live_count_high_byte
	localparam logic [3:0] ADDR_PRESET_LO = 4'h7; // write: preset_low_byte
	localparam logic [3:0] ADDR_COUNT_LO  = 4'h7; // read: live_count_low_byte
	localparam logic [3:0] ADDR_OUTCFG    = 4'hD; // write: out_port_config_reg
	localparam logic [3:0] ADDR_START     = 4'hE; // read: start command
	localparam logic [3:0] ADDR_STOP      = 4'hF; // read: stop command

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int MODE_LSB   = 4;
	localparam int MODE_MSB   = 6;
	localparam int OUTCFG_LSB = 2;
	localparam int OUTCFG_MSB = 3;
	localparam int READY_BIT  = 3;

	// ----------------------------------------
	// reset values and counting constants
	// ----------------------------------------
	localparam logic [7:0]  MASK_RST   = 8'h00;
	localparam logic [2:0]  MODE_RST   = 3'h0;
	localparam logic [1:0]  OUTCFG_RST = 2'h0;
	localparam logic [15:0] PRESET_RST = 16'h0002;
	localparam logic [15:0] COUNT_RST  = 16'h0000;
	localparam logic [15:0] COUNT_ONE  = 16'h0001;
	localparam logic [3:0]  DIV_LAST   = 4'hF; // divide by sixteen

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRC_CNT_PIN   = 3'h0,
		SRC_CNT_TXA   = 3'h1,
		SRC_CNT_TXB   = 3'h2,
		SRC_CNT_XT16  = 3'h3,
		SRC_TMR_PIN   = 3'h4,
		SRC_TMR_PIN16 = 3'h5,
		SRC_TMR_XT    = 3'h6,
		SRC_TMR_XT16  = 3'h7
	} ct_src_t;

	typedef enum logic [1:0] {
		OP3_SEL_REG = 2'h0,
		OP3_SEL_CT  = 2'h1,
		OP3_SEL_TXB = 2'h2,
		OP3_SEL_RXB = 2'h3
	} op3_sel_t;

	typedef enum logic [1:0] {
		CT_IDLE = 2'h1,
		CT_RUN  = 2'h2
	} ct_state_t;

endpackage : ct_pkg

// ===== logic/ct_clock_select.sv
/*
 * source clock selection and prescaler for the counter/timer.
 * assumes all source pins are synchronous to clock and much slower than it.
 */
`timescale 1ns/1ps
module ct_clock_select (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [2:0] mode_sel,
	input  wire logic       in_port_bit2,
	input  wire logic       chan_a_tx_1x_clock,
	input  wire logic       chan_b_tx_1x_clock,
	input  wire logic       crystal_clock_in,
	output logic            tick
);

	// ----------------------------------------
	// rising edge of each source
	// ----------------------------------------
	logic [3:0] src;
	logic [3:0] prev_q;
	logic [3:0] prev_d;
	logic [3:0] rise;
	logic [3:0] div_q;
	logic [3:0] div_d;
	logic       base;
	logic       use_div;
	logic       tick_q;
	logic       tick_d;

	assign src = {crystal_clock_in, chan_b_tx_1x_clock, chan_a_tx_1x_clock, in_port_bit2};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_edge
			assign rise[g] = src[g] & ~prev_q[g];
		end
	endgenerate

	// ----------------------------------------
	// mux and divide
	// ----------------------------------------
	always_comb begin
		prev_d  = src;
		use_div = 1'b0;
		case (ct_pkg::ct_src_t'(mode_sel))
			ct_pkg::SRC_CNT_PIN:   base = rise[0];
			ct_pkg::SRC_CNT_TXA:   base = rise[1];
			ct_pkg::SRC_CNT_TXB:   base = rise[2];
			ct_pkg::SRC_TMR_PIN:   base = rise[0];
			ct_pkg::SRC_TMR_XT:    base = rise[3];
			ct_pkg::SRC_TMR_PIN16: begin
				base    = rise[0];
				use_div = 1'b1;
			end
			default: begin
				base    = rise[3];
				use_div = 1'b1;
			end
		endcase
		div_d  = div_q;
		tick_d = 1'b0;
		if (base) begin
			div_d  = div_q + 4'h1;
			tick_d = ~use_div | (div_q == ct_pkg::DIV_LAST);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prev_q <= 4'h0;
			div_q  <= 4'h0;
			tick_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule : ct_clock_select

// ===== logic/host_bus_port.sv
/*
 * strobe decoder for the eight-bit host bus.
 * assumes bus pins are synchronous to clock; one pulse per read or write.
 */
`timescale 1ns/1ps
module host_bus_port (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       cs_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] data_in,
	output logic            rd_pulse,
	output logic            wr_pulse,
	output logic [3:0]      acc_addr,
	output logic [7:0]      acc_data
);

	// ----------------------------------------
	// strobe edges
	// ----------------------------------------
	logic       rd_n_q;
	logic       wr_n_q;
	logic       cs_n_q;
	logic [3:0] addr_q;
	logic [7:0] din_q;
	logic       rd_q;
	logic       rd_d;
	logic       wr_q;
	logic       wr_d;
	logic [3:0] acc_addr_q;
	logic [3:0] acc_addr_d;
	logic [7:0] acc_data_q;
	logic [7:0] acc_data_d;

	// reads act on the falling strobe, writes on the rising one so data has settled
	always_comb begin
		rd_d       = ~rd_n & rd_n_q & ~cs_n;
		wr_d       = wr_n & ~wr_n_q & ~cs_n_q;
		acc_addr_d = acc_addr_q;
		acc_data_d = acc_data_q;
		if (rd_d) begin
			acc_addr_d = addr;
		end else if (wr_d) begin
			acc_addr_d = addr_q;
			acc_data_d = din_q;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_n_q     <= 1'b1;
			wr_n_q     <= 1'b1;
			cs_n_q     <= 1'b1;
			addr_q     <= 4'h0;
			din_q      <= 8'h00;
			rd_q       <= 1'b0;
			wr_q       <= 1'b0;
			acc_addr_q <= 4'h0;
			acc_data_q <= 8'h00;
		end else begin
			rd_n_q     <= rd_n;
			wr_n_q     <= wr_n;
			cs_n_q     <= cs_n;
			addr_q     <= addr;
			din_q      <= data_in;
			rd_q       <= rd_d;
			wr_q       <= wr_d;
			acc_addr_q <= acc_addr_d;
			acc_data_q <= acc_data_d;
		end
	end

	assign rd_pulse = rd_q;
	assign wr_pulse = wr_q;
	assign acc_addr = acc_addr_q;
	assign acc_data = acc_data_q;

endmodule : host_bus_port

// ===== bench/ct_timer_props.sv
/*
 * checker for the counter/timer top ports.
 * assumes bus strobes and status sources are synchronous to clock.
 */
`timescale 1ns/1ps
module ct_timer_props (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       cs_n,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic [7:0] other_status,
	input wire logic       irq_out_n,
	input wire logic       out_port_bit3_oe,
	input wire logic       out_port_bit3_out
);
	// ----------------------------------------
	// shadow of the mask, so gating can be judged
	// ----------------------------------------
	logic       rd_prev_q, rd_prev_d, wr_prev_q, wr_prev_d, rd_take, wr_take;
	logic [3:0] la_q, la_d;
	logic [7:0] ld_q, ld_d, mask_q, mask_d;
	always_comb begin
		rd_take = !cs_n && !rd_n && rd_prev_q;
		wr_take = !cs_n && wr_n && !wr_prev_q;
		rd_prev_d = rd_n;
		wr_prev_d = wr_n;
		la_d = (!cs_n && !wr_n) ? addr : la_q;
		ld_d = (!cs_n && !wr_n) ? data_in : ld_q;
		mask_d = (wr_take && la_q == ct_pkg::ADDR_MASK) ? ld_q : mask_q;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_prev_q <= 1'b1;
			wr_prev_q <= 1'b1;
			la_q <= 4'h0;
			ld_q <= 8'h00;
			mask_q <= 8'h00;
		end else begin
			rd_prev_q <= rd_prev_d;
			wr_prev_q <= wr_prev_d;
			la_q <= la_d;
			ld_q <= ld_d;
			mask_q <= mask_d;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_oe_on; (!cs_n && !rd_n) |=> data_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("read drive missing");
	property p_oe_off; !(!cs_n && !rd_n) |=> !data_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("read drive left on");
	property p_hold; !$past(rd_take, 2) && !$past(rd_take, 3) |-> $stable(data_out); endproperty
	a_hold: assert property (p_hold) else $error("read data moved without a read");
	property p_unmapped; rd_take && addr == 4'h0 |-> ##3 data_out == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_status;
		rd_take && addr == ct_pkg::ADDR_STATUS && $stable(other_status)
			|-> ##3 (data_out & 8'hF7) == ($past(other_status, 3) & 8'hF7);
	endproperty
	a_status: assert property (p_status) else $error("status read altered");
	property p_irq_on; ((other_status & mask_q & 8'hF7) != 8'h00)[*5] |-> !irq_out_n; endproperty
	a_irq_on: assert property (p_irq_on) else $error("unmasked status gave no interrupt");
	property p_irq_off; ((other_status & mask_q) == 8'h00 && !mask_q[3])[*5] |-> irq_out_n; endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked status gave interrupt");
	property p_stop_clears;
		rd_take && addr == ct_pkg::ADDR_STOP && mask_q == 8'h08 && other_status == 8'h00
			|-> ##[3:6] irq_out_n;
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("stop left ready set");
	c_irq: cover property (!irq_out_n);
	c_stop: cover property (rd_take && addr == ct_pkg::ADDR_STOP);
	c_pin_low: cover property (out_port_bit3_oe && !out_port_bit3_out);
endmodule : ct_timer_props

bind ct_timer_top ct_timer_props u_props (
	.clock(clock), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
	.data_out(data_out), .data_oe(data_oe), .other_status(other_status), .irq_out_n(irq_out_n),
	.out_port_bit3_oe(out_port_bit3_oe), .out_port_bit3_out(out_port_bit3_out)
);

// ===== bench/host_model.sv
/*
 * host processor model for the eight-bit bus.
 * assumes the bench calls its tasks one at a time, after reset.
 */
`timescale 1ns/1ps
module host_model (
	input  wire logic       clock,
	input  wire logic [7:0] data_out,
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic [3:0]      addr,
	output logic [7:0]      data_in
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 4'h0;
		data_in = 8'h00;
	end
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		cs_n = 1'b0;
		wr_n = 1'b0;
		addr = a;
		data_in = d;
		@(posedge clock);
		#1;
		wr_n = 1'b1;
		@(posedge clock);
		#1;
		cs_n = 1'b1;
		addr = ~a; // released lines never keep the old value
		data_in = ~d;
		repeat (3) @(posedge clock);
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		#1;
		cs_n = 1'b0;
		rd_n = 1'b0;
		addr = a;
		repeat (3) @(posedge clock);
		#1;
		d = data_out;
		rd_n = 1'b1;
		cs_n = 1'b1;
		addr = ~a;
		repeat (3) @(posedge clock);
		#1;
	endtask : rd
	// callers only pass 0002 or more
	task automatic set_preset(input logic [15:0] v);
		wr(ct_pkg::ADDR_PRESET_HI, v[15:8]);
		wr(ct_pkg::ADDR_PRESET_LO, v[7:0]);
	endtask : set_preset
endmodule : host_model

// ===== bench/tb_counter_timer_with_irq_mask.sv
/*
 * self-checking bench for the counter/timer top.
 * assumes the host model owns the bus; the bench drives the count source.
 */
`timescale 1ns/1ps
module tb_counter_timer_with_irq_mask;
	logic       clock, rst, src, out_reg_bit3, rxb;
	logic       cs_n, rd_n, wr_n, data_oe, irq_out_n, out_port_bit3_out, out_port_bit3_oe;
	logic [3:0] addr;
	logic [1:0] lane;
	logic [7:0] data_in, data_out, other_status;
	int         err_total, num_checks, cycles;
	wire        pin_lvl = out_port_bit3_oe ? out_port_bit3_out : 1'b1; // pull-up when released
	wire  [3:0] srcs = {3'b000, src} << lane; // lane 0 pin, 1 and 2 transmit, 3 crystal

	initial clock = 1'b0;
	always #4 clock = ~clock;

	host_model host (.clock(clock), .data_out(data_out), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.addr(addr), .data_in(data_in));
	// one source line pulses at a time, picked by lane
	ct_timer_top uut (.clock(clock), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .crystal_clock_in(srcs[3]),
		.in_port_bit2(srcs[0]), .chan_a_tx_1x_clock(srcs[1]), .chan_b_tx_1x_clock(srcs[2]),
		.chan_b_rx_1x_clock(rxb), .out_reg_bit3(out_reg_bit3), .other_status(other_status),
		.irq_out_n(irq_out_n), .out_port_bit3_out(out_port_bit3_out), .out_port_bit3_oe(out_port_bit3_oe));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clock);
			#1;
			src = 1'b1;
			repeat (2) @(posedge clock);
			#1;
			src = 1'b0;
			repeat (2) @(posedge clock);
		end
		repeat (5) @(posedge clock);
		#1;
	endtask : pulses
	task automatic rd_cnt(output logic [15:0] v);
		logic [7:0] h, l;
		host.rd(ct_pkg::ADDR_COUNT_HI, h);
		host.rd(ct_pkg::ADDR_COUNT_LO, l);
		v = {h, l};
	endtask : rd_cnt

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [7:0] d;
		check("irq_out_n", 16'(irq_out_n), 16'h0001);
		check("pin drive", 16'({out_port_bit3_oe, out_port_bit3_out}), 16'h0002);
		host.rd(ct_pkg::ADDR_STATUS, d);
		check("status", 16'(d), 16'h0000);
	endtask : t_reset
	task automatic t_mask;
		logic [7:0] d;
		other_status = 8'h01;
		host.wr(ct_pkg::ADDR_MASK, 8'h00);
		repeat (5) @(posedge clock);
		#1;
		check("irq_out_n", 16'(irq_out_n), 16'h0001);
		host.wr(ct_pkg::ADDR_MASK, 8'h01);
		repeat (5) @(posedge clock);
		#1;
		check("irq_out_n", 16'(irq_out_n), 16'h0000);
		host.wr(ct_pkg::ADDR_MASK, 8'h00);
		host.rd(ct_pkg::ADDR_STATUS, d);
		check("status", 16'(d), 16'h0001);
		check("irq_out_n", 16'(irq_out_n), 16'h0001);
		host.rd(4'h0, d);
		check("unmapped", 16'(d), 16'h0000);
		other_status = 8'h00;
	endtask : t_mask
	task automatic t_counter;
		logic [7:0]  d;
		logic [15:0] c;
		host.wr(ct_pkg::ADDR_OUTCFG, 8'h04);
		host.wr(ct_pkg::ADDR_MASK, 8'h08);
		host.set_preset(16'h0003);
		host.rd(ct_pkg::ADDR_START, d);
		pulses(2);
		check("pin", 16'(pin_lvl), 16'h0001);
		check("irq_out_n", 16'(irq_out_n), 16'h0001);
		pulses(1);
		check("pin", 16'(pin_lvl), 16'h0000);
		check("irq_out_n", 16'(irq_out_n), 16'h0000);
		pulses(1);
		host.rd(ct_pkg::ADDR_STOP, d);
		rd_cnt(c); // stopped first so no borrow between halves
		check("count", c, 16'hFFFF);
		check("pin", 16'(pin_lvl), 16'h0001);
		host.rd(ct_pkg::ADDR_STATUS, d);
		check("ready", 16'(d[3]), 16'h0000);
		host.set_preset(16'h0005);
		pulses(1);
		rd_cnt(c);
		check("count", c, 16'hFFFF);
		host.rd(ct_pkg::ADDR_START, d);
		rd_cnt(c);
		check("count", c, 16'h0005);
		pulses(1);
		rd_cnt(c);
		check("count", c, 16'h0004);
		host.rd(ct_pkg::ADDR_STOP, d);
	endtask : t_counter
	task automatic t_timer;
		logic [7:0] d;
		host.wr(ct_pkg::ADDR_MODE, 8'h40);
		host.set_preset(16'h0002);
		host.rd(ct_pkg::ADDR_START, d);
		check("wave", 16'(pin_lvl), 16'h0001);
		pulses(2);
		check("wave", 16'(pin_lvl), 16'h0000);
		pulses(2);
		check("wave", 16'(pin_lvl), 16'h0001);
		check("irq_out_n", 16'(irq_out_n), 16'h0000);
		host.rd(ct_pkg::ADDR_STOP, d);
		check("irq_out_n", 16'(irq_out_n), 16'h0001);
		pulses(2);
		check("wave", 16'(pin_lvl), 16'h0000);
		host.rd(ct_pkg::ADDR_START, d);
		check("wave", 16'(pin_lvl), 16'h0001);
	endtask : t_timer
	// counter from one source; a stray pin pulse must not count
	task automatic cnt_run(input logic [7:0] mode, input logic [1:0] ln, input int n);
		logic [7:0]  d;
		logic [15:0] c;
		host.wr(ct_pkg::ADDR_MODE, mode);
		host.rd(ct_pkg::ADDR_START, d);
		lane = ln;
		pulses(n);
		lane = 2'd0;
		pulses(1);
		host.rd(ct_pkg::ADDR_STOP, d);
		rd_cnt(c);
		check("count", c, 16'h0001);
	endtask : cnt_run
	// timer half periods; an undivided source would toggle far too often
	task automatic tmr_run(input logic [7:0] mode, input logic [1:0] ln, input int n);
		logic [7:0] d;
		host.wr(ct_pkg::ADDR_MODE, mode);
		lane = ln;
		host.rd(ct_pkg::ADDR_START, d);
		pulses(n);
		check("wave", 16'(pin_lvl), 16'h0000);
		pulses(n);
		check("wave", 16'(pin_lvl), 16'h0001);
	endtask : tmr_run
	task automatic pin_is(input logic v);
		repeat (3) @(posedge clock);
		#1;
		check("pin", 16'(pin_lvl), 16'(v));
	endtask : pin_is
	task automatic t_sources;
		host.set_preset(16'h0002);
		cnt_run(8'h10, 2'd1, 1);
		cnt_run(8'h20, 2'd2, 1);
		cnt_run(8'h30, 2'd3, 16);
		tmr_run(8'h50, 2'd0, 32);
		tmr_run(8'h60, 2'd3, 2);
		tmr_run(8'h70, 2'd3, 32);
		host.wr(ct_pkg::ADDR_OUTCFG, 8'h08);
		lane = 2'd2;
		src = 1'b1;
		pin_is(1'b1);
		src = 1'b0;
		pin_is(1'b0);
		host.wr(ct_pkg::ADDR_OUTCFG, 8'h0C);
		rxb = 1'b1;
		pin_is(1'b1);
		rxb = 1'b0;
		pin_is(1'b0);
		host.wr(ct_pkg::ADDR_OUTCFG, 8'h00);
		out_reg_bit3 = 1'b0;
		pin_is(1'b1);
		out_reg_bit3 = 1'b1;
		pin_is(1'b0);
		lane = 2'd0;
	endtask : t_sources

	// ----------------------------------------
	// main sequence and hang guard
	// ----------------------------------------
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		rst = 1'b1;
		src = 1'b0;
		lane = 2'd0;
		rxb = 1'b0;
		out_reg_bit3 = 1'b1;
		other_status = 8'h00;
		repeat (4) @(posedge clock);
		#1;
		rst = 1'b0;
		@(posedge clock);
		#1;
		t_reset();
		t_mask();
		t_counter();
		t_timer();
		t_sources();
		wrap_up();
	end
endmodule : tb_counter_timer_with_irq_mask
